// ---- hdl/fifo_pkg.sv ----
/*
  Shared constants for the deep FIFO status-flag block: register byte
  addresses, status field positions, default flag offsets and bus answers.
  Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
*/
package fifo_pkg;

  // Register byte addresses
  localparam logic [7:0] EMPTY_OFF_ADDR = 8'h00;
  localparam logic [7:0] FULL_OFF_ADDR = 8'h04;
  localparam logic [7:0] STATUS_ADDR = 8'h08;
  localparam logic [7:0] LEVEL_ADDR = 8'h0c;

  // Status register field positions
  localparam int ST_FALL_THROUGH = 0;
  localparam int ST_SERIAL_LOAD = 1;
  localparam int ST_EMPTY_PIN = 2;
  localparam int ST_FULL_PIN = 3;
  localparam int ST_HALF_PIN = 4;
  localparam int ST_ALMOST_EMPTY_PIN = 5;
  localparam int ST_ALMOST_FULL_PIN = 6;

  // Default offsets chosen by the loading method at reset
  localparam logic [9:0] DEF_OFF_SERIAL = 10'h3ff;
  localparam logic [9:0] DEF_OFF_PARALLEL = 10'h07f;

  // Bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Register select codes
  typedef enum logic [2:0] {
    SEL_EMPTY_OFF,
    SEL_FULL_OFF,
    SEL_STATUS,
    SEL_LEVEL,
    SEL_NONE
  } reg_sel_t;

endpackage : fifo_pkg

// ---- hdl/ram_port_if.sv ----
/*
  Port bundle between the flag logic and its word store.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps

interface ram_port_if #(
  parameter int AW = 16,
  parameter int DW = 9
);
  logic wr_en;
  logic [AW-1:0] wr_addr;
  logic [DW-1:0] wr_data;
  logic rd_en;
  logic [AW-1:0] rd_addr;
  logic [DW-1:0] rd_data;

  // Flag logic drives, store answers
  modport ctrl (
    output wr_en, wr_addr, wr_data, rd_en, rd_addr,
    input rd_data
  );
  modport store (
    input wr_en, wr_addr, wr_data, rd_en, rd_addr,
    output rd_data
  );
endinterface : ram_port_if

// ---- hdl/word_store.sv ----
/*
  Word store of the FIFO: one write port, one registered read port.
  Assumes the caller never writes a slot that is still unread.
*/
`timescale 1ns/1ps

module word_store #(
  parameter int AW = 16,
  parameter int DW = 9
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Store port
  ram_port_if.store port
);

  logic [DW-1:0] mem [2**AW];
  logic [DW-1:0] rd_data_q;
  logic [DW-1:0] rd_data_d;

  // Memory write, no reset on the array
  always_ff @(posedge aclk)
  begin
    if (port.wr_en)
      mem[port.wr_addr] <= port.wr_data;
  end

  // Output word holds until the next fetch
  always_comb
  begin
    rd_data_d = rd_data_q;
    if (!aresetn)
      rd_data_d = '0;
    else if (port.rd_en)
      rd_data_d = mem[port.rd_addr];
  end

  always_ff @(posedge aclk)
  begin
    rd_data_q <= rd_data_d;
  end

  assign port.rd_data = rd_data_q;

endmodule : word_store

// ---- hdl/dual_clock_fifo_status_flags.sv ----
/*
  Deep 9-bit FIFO with standard and fall-through timing, empty, full,
  half-full and programmable almost flags, serial offset loading on pins
  and offset access over AXI4-Lite.
  Assumes writer, reader and bus master all run on aclk, so the pointer
  crossings are plain two-stage delays that keep the flag latencies.
*/
`timescale 1ns/1ps

// Functional notes
// - Reset latches timing mode from mode pin: low standard, high fall-through.
// - Fall-through: first word reaches outputs three edges after write, unrequested.
// - Standard: empty flag rises after first word enters an empty FIFO.
// - Standard: almost-empty high from n+1 words, low from 0 to n.
// - Standard: half-full low from half depth plus one words.
// - Standard: almost-full low from depth minus m words.
// - Standard: full flag low at depth words; writes blocked meanwhile.
// - Standard: almost-empty falls when draining reaches n words.
// - First read from full releases full indication in both modes.
// - Last word read signals empty; read enable ignored while empty.
// - Standard: empty and full flags pass two register stages.
// - Fall-through: output-ready low once first word is valid on outputs.
// - Fall-through: almost-empty high from n+2 words.
// - Fall-through: half-full low from half depth plus two words.
// - Fall-through: almost-full low from depth plus one minus m words.
// - Fall-through: capacity includes output register; input-ready high then.
// - Fall-through: almost-empty falls when draining reaches n+1 words.
// - Fall-through: output-ready and input-ready both two stages, as in standard.
// - Reset latches loading method: high serial 3ff, low parallel 07f.
// - Offsets readable only through the parallel register path.
// - Offsets may be reprogrammed any time after reset.
// - Serial load shifts one bit per edge, empty LSB to full MSB.
module dual_clock_fifo_status_flags #(
  parameter int AW = 16,
  parameter int DW = 9,
  parameter int AXI_AW = 8
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus, write channels
  input wire logic [AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Register bus, read channels
  input wire logic [AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Writer
  input wire logic wr_en_n,
  input wire logic [DW-1:0] data_in,
  // Reader
  input wire logic rd_en_n,
  output logic [DW-1:0] data_out,
  // Setup pins
  input wire logic mode_or_serial_input,
  input wire logic load_select_n,
  input wire logic serial_enable_n,
  // Status flags
  output logic full_flag_n,
  output logic input_ready_n,
  output logic empty_flag_n,
  output logic output_ready_n,
  output logic almost_full_flag_n,
  output logic almost_empty_flag_n,
  output logic half_full_indicator_n
);

  localparam int PW = AW + 2;
  localparam int OW = AW;
  localparam int BW = $clog2(2 * AW);
  localparam logic [PW-1:0] DEPTH = PW'(1) << AW;
  localparam logic [PW-1:0] HALF = PW'(1) << (AW - 1);

  // Offset widened to pointer width
  function automatic logic [PW-1:0] widen(input logic [OW-1:0] v);
    widen = {2'b00, v};
  endfunction : widen

  // Byte-lane merge for register writes
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0] strb);
    for (int i = 0; i < 4; i++)
      merge[8*i +: 8] = strb[i] ? new_v[8*i +: 8] : old_v[8*i +: 8];
  endfunction : merge

  // Word address decode, shared by both bus directions
  function automatic fifo_pkg::reg_sel_t decode(input logic [AXI_AW-1:0] a);
    logic [7:0] w;
    w = {a[7:2], 2'b00};
    if (w == fifo_pkg::EMPTY_OFF_ADDR)
      decode = fifo_pkg::SEL_EMPTY_OFF;
    else if (w == fifo_pkg::FULL_OFF_ADDR)
      decode = fifo_pkg::SEL_FULL_OFF;
    else if (w == fifo_pkg::STATUS_ADDR)
      decode = fifo_pkg::SEL_STATUS;
    else if (w == fifo_pkg::LEVEL_ADDR)
      decode = fifo_pkg::SEL_LEVEL;
    else
      decode = fifo_pkg::SEL_NONE;
  endfunction : decode

  // Bus slave state
  logic aw_got_q, aw_got_d, w_got_q, w_got_d;
  logic awready_q, awready_d, wready_q, wready_d;
  logic bvalid_q, bvalid_d, arready_q, arready_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [AXI_AW-1:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d, status_v;
  logic [3:0] wstrb_q, wstrb_d;
  logic reg_wr, ar_take;
  fifo_pkg::reg_sel_t wsel, rsel;

  // Configuration state
  logic fall_through_mode_q, fall_through_mode_d, serial_q, serial_d;
  logic [OW-1:0] e_off_q, e_off_d, f_off_q, f_off_d;
  logic [BW-1:0] bit_idx_q, bit_idx_d;
  logic [2*OW-1:0] offs_v;

  // Write side state
  logic [PW-1:0] wr_ptr_q, wr_ptr_d, rd_s1_q, rd_s2_q, cons_s1_q, cons_s2_q;
  logic [PW-1:0] wcnt, wcnt_d, cap;
  logic wr_take;

  // Read side state
  logic [PW-1:0] rd_ptr_q, rd_ptr_d, cons_q, cons_d, wr_s1_q, wr_s2_q;
  logic [PW-1:0] rcnt_d;
  logic ov_q, ov_d, fetch, take, ren_ok, ram_has;

  // Flag pins
  logic ef_q, ef_d, ff_q, ff_d, ae_q, ae_d, af_q, af_d, hf_q, hf_d;

  ram_port_if #(.AW(AW), .DW(DW)) ram ();

  word_store #(.AW(AW), .DW(DW)) u_store (
    .aclk(aclk),
    .aresetn(aresetn),
    .port(ram.store)
  );

  assign ram.wr_en = wr_take;
  assign ram.wr_addr = wr_ptr_q[AW-1:0];
  assign ram.wr_data = data_in;
  assign ram.rd_en = fetch;
  assign ram.rd_addr = rd_ptr_q[AW-1:0];

  // Bus slave: address and data taken in either order, one write at a time
  always_comb
  begin
    aw_got_d = aw_got_q || (s_axi_awvalid && awready_q);
    w_got_d = w_got_q || (s_axi_wvalid && wready_q);
    awaddr_d = (s_axi_awvalid && awready_q) ? s_axi_awaddr : awaddr_q;
    wdata_d = (s_axi_wvalid && wready_q) ? s_axi_wdata : wdata_q;
    wstrb_d = (s_axi_wvalid && wready_q) ? s_axi_wstrb : wstrb_q;
    wsel = decode(awaddr_q);
    reg_wr = aw_got_q && w_got_q && !bvalid_q;
    bvalid_d = bvalid_q ? !s_axi_bready : reg_wr;
    bresp_d = bresp_q;
    if (reg_wr)
    begin
      aw_got_d = 1'b0;
      w_got_d = 1'b0;
      bresp_d = (wsel == fifo_pkg::SEL_NONE) ? fifo_pkg::RESP_SLVERR :
                fifo_pkg::RESP_OKAY;
    end
    awready_d = !aw_got_d && !bvalid_d;
    wready_d = !w_got_d && !bvalid_d;
    ar_take = s_axi_arvalid && arready_q;
    rvalid_d = rvalid_q ? !s_axi_rready : ar_take;
    arready_d = !rvalid_d;
    rsel = decode(s_axi_araddr);
    status_v = '0;
    status_v[fifo_pkg::ST_FALL_THROUGH] = fall_through_mode_q;
    status_v[fifo_pkg::ST_SERIAL_LOAD] = serial_q;
    status_v[fifo_pkg::ST_EMPTY_PIN] = ef_q;
    status_v[fifo_pkg::ST_FULL_PIN] = ff_q;
    status_v[fifo_pkg::ST_HALF_PIN] = hf_q;
    status_v[fifo_pkg::ST_ALMOST_EMPTY_PIN] = ae_q;
    status_v[fifo_pkg::ST_ALMOST_FULL_PIN] = af_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (ar_take)
    begin
      rresp_d = fifo_pkg::RESP_OKAY;
      // Offsets are only read back here, never shifted out serially
      case (rsel)
        fifo_pkg::SEL_EMPTY_OFF: rdata_d = 32'(e_off_q);
        fifo_pkg::SEL_FULL_OFF: rdata_d = 32'(f_off_q);
        fifo_pkg::SEL_STATUS: rdata_d = status_v;
        fifo_pkg::SEL_LEVEL: rdata_d = 32'(wcnt);
        default:
        begin
          rdata_d = '0;
          rresp_d = fifo_pkg::RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= fifo_pkg::RESP_OKAY;
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rresp_q <= fifo_pkg::RESP_OKAY;
      rdata_q <= '0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end
    else
    begin
      aw_got_q <= aw_got_d;
      w_got_q <= w_got_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
    end
  end

  // Setup: straps caught while reset is held, offsets loaded later
  always_comb
  begin
    fall_through_mode_d = fall_through_mode_q;
    serial_d = serial_q;
    bit_idx_d = bit_idx_q;
    offs_v = {f_off_q, e_off_q};
    if (!aresetn)
    begin
      fall_through_mode_d = mode_or_serial_input;
      serial_d = load_select_n;
      bit_idx_d = '0;
      offs_v = load_select_n ?
               {OW'(fifo_pkg::DEF_OFF_SERIAL), OW'(fifo_pkg::DEF_OFF_SERIAL)} :
               {OW'(fifo_pkg::DEF_OFF_PARALLEL),
                OW'(fifo_pkg::DEF_OFF_PARALLEL)};
    end
    else
    begin
      // Mode pin doubles as serial data once reset is released
      if (serial_q && !load_select_n && !serial_enable_n)
      begin
        offs_v[bit_idx_q] = mode_or_serial_input;
        bit_idx_d = (bit_idx_q == BW'(2 * OW - 1)) ? '0 :
                    bit_idx_q + 1'b1;
      end
      // Bus write wins over a serial bit in the same cycle
      if (reg_wr && wsel == fifo_pkg::SEL_EMPTY_OFF)
        offs_v[OW-1:0] = OW'(merge(32'(e_off_q), wdata_q, wstrb_q));
      if (reg_wr && wsel == fifo_pkg::SEL_FULL_OFF)
        offs_v[2*OW-1:OW] = OW'(merge(32'(f_off_q), wdata_q, wstrb_q));
    end
    f_off_d = offs_v[2*OW-1:OW];
    e_off_d = offs_v[OW-1:0];
  end

  always_ff @(posedge aclk)
  begin
    fall_through_mode_q <= fall_through_mode_d;
    serial_q <= serial_d;
    bit_idx_q <= bit_idx_d;
    e_off_q <= e_off_d;
    f_off_q <= f_off_d;
  end

  // Write side: room judged on delayed read pointers, so never optimistic
  always_comb
  begin
    cap = fall_through_mode_q ? DEPTH + 1'b1 : DEPTH;
    wcnt = wr_ptr_q - cons_s2_q;
    wr_take = !wr_en_n && load_select_n && (wcnt < cap) &&
              ((wr_ptr_q - rd_s2_q) < DEPTH);
    wr_ptr_d = aresetn ? wr_ptr_q + PW'(wr_take) : '0;
    wcnt_d = wr_ptr_d - cons_s2_q;
  end

  // Pointer crossings: two stages each way
  always_ff @(posedge aclk)
  begin
    wr_ptr_q <= wr_ptr_d;
    if (!aresetn)
    begin
      rd_s1_q <= '0;
      rd_s2_q <= '0;
      cons_s1_q <= '0;
      cons_s2_q <= '0;
      wr_s1_q <= '0;
      wr_s2_q <= '0;
    end
    else
    begin
      rd_s1_q <= rd_ptr_q;
      rd_s2_q <= rd_s1_q;
      cons_s1_q <= cons_q;
      cons_s2_q <= cons_s1_q;
      wr_s1_q <= wr_ptr_q;
      wr_s2_q <= wr_s1_q;
    end
  end

  // Read side: fetch from store, count words handed to the reader
  always_comb
  begin
    ren_ok = !rd_en_n && load_select_n;
    ram_has = (wr_s2_q != rd_ptr_q);
    if (fall_through_mode_q)
    begin
      take = ren_ok && ov_q;
      fetch = ram_has && (!ov_q || take);
    end
    else
    begin
      take = ren_ok && ram_has;
      fetch = take;
    end
    ov_d = aresetn && fall_through_mode_q && (fetch || (ov_q && !take));
    rd_ptr_d = aresetn ? rd_ptr_q + PW'(fetch) : '0;
    cons_d = aresetn ? cons_q + PW'(take) : '0;
    rcnt_d = wr_s2_q - cons_d;
  end

  always_ff @(posedge aclk)
  begin
    rd_ptr_q <= rd_ptr_d;
    cons_q <= cons_d;
    ov_q <= ov_d;
  end

  // Flag pins, thresholds shifted by one in fall-through mode
  always_comb
  begin
    if (!aresetn)
    begin
      ef_d = mode_or_serial_input;
      ff_d = !mode_or_serial_input;
      ae_d = 1'b0;
      af_d = 1'b1;
      hf_d = 1'b1;
    end
    else if (fall_through_mode_q)
    begin
      ef_d = !ov_d;
      ff_d = (wcnt_d == cap);
      ae_d = rcnt_d > widen(e_off_q) + 1'b1;
      af_d = !(wcnt_d >= cap - widen(f_off_q));
      hf_d = !(wcnt_d > HALF + 1'b1);
    end
    else
    begin
      ef_d = (rcnt_d != '0);
      ff_d = (wcnt_d != cap);
      ae_d = rcnt_d > widen(e_off_q);
      af_d = !(wcnt_d >= cap - widen(f_off_q));
      hf_d = !(wcnt_d > HALF);
    end
  end

  always_ff @(posedge aclk)
  begin
    ef_q <= ef_d;
    ff_q <= ff_d;
    ae_q <= ae_d;
    af_q <= af_d;
    hf_q <= hf_d;
  end

  // Shared pins: meaning follows the latched timing mode
  assign full_flag_n = ff_q;
  assign input_ready_n = ff_q;
  assign empty_flag_n = ef_q;
  assign output_ready_n = ef_q;
  assign almost_full_flag_n = af_q;
  assign almost_empty_flag_n = ae_q;
  assign half_full_indicator_n = hf_q;
  assign data_out = ram.rd_data;
  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;

endmodule : dual_clock_fifo_status_flags

// ---- sim/fifo_flags_monitor.sv ----
/*
  Checker for the FIFO flag block, watching the top-level pins only.
  Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps

module fifo_flags_monitor #(
  parameter int DW = 9
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Stream and setup pins
  input wire logic wr_en_n,
  input wire logic rd_en_n,
  input wire logic [DW-1:0] data_out,
  input wire logic mode_or_serial_input,
  input wire logic load_select_n,
  // Flags
  input wire logic full_flag_n,
  input wire logic empty_flag_n,
  input wire logic almost_full_flag_n,
  input wire logic almost_empty_flag_n,
  input wire logic half_full_indicator_n
);
  logic mode_q;
  logic mode_d;
  logic wr_fire;
  logic rd_fire;

  // Strap copy, so checks know which flag polarity applies
  always_comb
  begin
    mode_d = aresetn ? mode_q : mode_or_serial_input;
    wr_fire = !wr_en_n && load_select_n;
    rd_fire = !rd_en_n && load_select_n;
  end
  always_ff @(posedge aclk)
  begin
    mode_q <= mode_d;
  end

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_reset_state: assert property ($rose(aresetn) |->
    !almost_empty_flag_n && almost_full_flag_n && half_full_indicator_n
    && full_flag_n != mode_q && empty_flag_n == mode_q)
    else $error("flag levels after reset wrong");
  chk_first_word: assert property (wr_fire
    && empty_flag_n == mode_q |-> ##[1:4] empty_flag_n != mode_q)
    else $error("first word unflagged");
  chk_full_hold: assert property (!mode_q && !full_flag_n
    && rd_en_n && $past(rd_en_n) && $past(rd_en_n, 2) && $past(rd_en_n, 3)
    |=> !full_flag_n) else $error("full flag dropped without a read");
  chk_full_release: assert property (!mode_q && !full_flag_n
    && rd_fire |-> ##[1:4] full_flag_n) else $error("full not released");
  chk_ready_release: assert property (mode_q && full_flag_n
    && rd_fire |-> ##[1:4] !full_flag_n) else $error("input ready stuck");
  chk_full_almost: assert property ($fell(full_flag_n) && !mode_q
    |-> ##[0:2] !almost_full_flag_n) else $error("full without almost-full");
  chk_data_hold: assert property ((!mode_q || !empty_flag_n)
    && rd_en_n |=> $stable(data_out)) else $error("output word moved");
  chk_half_cause: assert property ($fell(half_full_indicator_n)
    |-> !$past(wr_en_n) || !$past(wr_en_n, 2) || !$past(wr_en_n, 3))
    else $error("half-full fell without a write");

  // Main scenarios reached
  cover property (!mode_q && $fell(full_flag_n));
  cover property (mode_q && $rose(full_flag_n));
  cover property (!mode_q && $rose(empty_flag_n));
endmodule : fifo_flags_monitor

bind dual_clock_fifo_status_flags fifo_flags_monitor #(.DW(DW)) mon_u (
  .aclk, .aresetn, .wr_en_n, .rd_en_n, .data_out, .mode_or_serial_input,
  .load_select_n, .full_flag_n, .empty_flag_n, .almost_full_flag_n,
  .almost_empty_flag_n, .half_full_indicator_n);

// ---- sim/fifo_stream_peer.sv ----
/*
  Writer and reader on the FIFO stream pins.
  Assumes calls start just after a clock edge, one at a time.
*/
`timescale 1ns/1ps

module fifo_stream_peer (
  // Clock
  input wire logic aclk,
  // Writer and reader pins
  output logic wr_en_n,
  output logic [8:0] data_in,
  output logic rd_en_n
);
  int unsigned seq = 0;

  initial
  begin
    wr_en_n = 1'b1;
    rd_en_n = 1'b1;
    data_in = 9'h1ff;
  end

  // One word per edge; idle data is inverted so stale words never match
  task automatic push(input int n);
    repeat (n)
    begin
      wr_en_n <= 1'b0;
      data_in <= seq[8:0];
      seq++;
      @(posedge aclk);
    end
    wr_en_n <= 1'b1;
    data_in <= ~data_in;
  endtask : push

  // Every word is asked for explicitly
  task automatic pop(input int n);
    rd_en_n <= 1'b0;
    repeat (n) @(posedge aclk);
    rd_en_n <= 1'b1;
  endtask : pop
endmodule : fifo_stream_peer

// ---- sim/dual_clock_fifo_status_flags_bench.sv ----
/*
  Self-checking bench: bus tasks, stream peer and flag steps, both modes.
  Assumes a 256-word store (AW 8) and the designed flag latencies.
*/
`timescale 1ns/1ps

module dual_clock_fifo_status_flags_bench;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic mode_or_serial_input = 1'b0, load_select_n = 1'b0;
  logic serial_enable_n = 1'b1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, rd_word;
  logic [1:0] resp;
  logic wr_en_n, rd_en_n;
  logic [8:0] data_in, data_out;
  logic full_flag_n, input_ready_n, empty_flag_n, output_ready_n;
  logic almost_full_flag_n, almost_empty_flag_n, half_full_indicator_n;
  int fail_count = 0;
  int num_checks = 0;
  int pushed = 0;
  // Flags: 0 half, 1 almost-full, 2 almost-empty, 3 empty, 4 full,
  // 5 output ready, 6 input ready
  wire [6:0] flags = {input_ready_n, output_ready_n, full_flag_n,
    empty_flag_n, almost_empty_flag_n, almost_full_flag_n,
    half_full_indicator_n};

  initial
  begin
    forever #10 aclk = ~aclk;
  end

  dual_clock_fifo_status_flags #(.AW(8)) dut_u (.aclk, .aresetn,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .wr_en_n,
    .data_in, .rd_en_n, .data_out, .mode_or_serial_input, .load_select_n,
    .serial_enable_n, .full_flag_n, .input_ready_n, .empty_flag_n,
    .output_ready_n, .almost_full_flag_n, .almost_empty_flag_n,
    .half_full_indicator_n);
  fifo_stream_peer peer_u (.aclk, .wr_en_n, .data_in, .rd_en_n);

  task automatic final_report;
    $display("Checks %0d, mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : final_report

  task automatic check_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_bit

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_word

  // Leading edge keeps a ready from being set twice in one step
  task automatic wr_check(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int i = 0; i < 50; i++)
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
      begin
        s_axi_bready <= 1'b0;
        check_word({30'h0, s_axi_bresp}, {30'h0, fifo_pkg::RESP_OKAY});
        return;
      end
    end
    check_bit(1'b0, 1'b1);
    final_report();
  endtask : wr_check

  task automatic rd_check(input logic [7:0] a, input logic [31:0] e);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int i = 0; i < 50; i++)
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
      begin
        s_axi_rready <= 1'b0;
        resp = s_axi_rresp;
        check_word(s_axi_rdata, e);
        return;
      end
    end
    check_bit(1'b0, 1'b1);
    final_report();
  endtask : rd_check

  // Straps held through all ten reset edges
  task automatic do_reset(input logic mode, input logic ld);
    aresetn <= 1'b0;
    mode_or_serial_input <= mode;
    load_select_n <= ld;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    load_select_n <= 1'b1;
    mode_or_serial_input <= 1'b0;
    @(posedge aclk);
  endtask : do_reset

  task automatic serial_load(input logic [15:0] v);
    load_select_n <= 1'b0;
    serial_enable_n <= 1'b0;
    for (int i = 0; i < 16; i++)
    begin
      mode_or_serial_input <= v[i];
      @(posedge aclk);
    end
    load_select_n <= 1'b1;
    serial_enable_n <= 1'b1;
  endtask : serial_load

  // Words in, words out, then let the flag pipelines settle
  task automatic step(input int p, input int q, input int idx,
    input logic exp);
    if (p > 0)
      peer_u.push(p);
    pushed += p;
    if (q > 0)
      peer_u.pop(q);
    repeat (6) @(posedge aclk);
    check_bit(flags[idx], exp);
  endtask : step

  initial
  begin
    @(posedge aclk);
    do_reset(1'b0, 1'b0);
    rd_check(fifo_pkg::STATUS_ADDR, 32'h58);
    rd_check(fifo_pkg::EMPTY_OFF_ADDR, 32'h7f);
    wr_check(fifo_pkg::EMPTY_OFF_ADDR, 32'h4);
    wr_check(fifo_pkg::FULL_OFF_ADDR, 32'h4);
    // No byte lane enabled, so the offset must stay as it was
    s_axi_wstrb <= 4'h0;
    wr_check(fifo_pkg::FULL_OFF_ADDR, 32'h9);
    s_axi_wstrb <= 4'hf;
    rd_check(fifo_pkg::FULL_OFF_ADDR, 32'h4);
    rd_check(8'h10, 32'h0);
    check_word({30'h0, resp}, {30'h0, fifo_pkg::RESP_SLVERR});
    step(1, 0, 3, 1'b1);
    step(3, 0, 2, 1'b0);
    step(1, 0, 2, 1'b1);
    step(123, 0, 0, 1'b1);
    step(1, 0, 0, 1'b0);
    step(122, 0, 1, 1'b1);
    step(1, 0, 1, 1'b0);
    step(3, 0, 4, 1'b1);
    step(2, 0, 4, 1'b0);
    rd_check(fifo_pkg::LEVEL_ADDR, 32'h100);
    step(0, 1, 4, 1'b1);
    check_word({23'h0, data_out}, 32'h0);
    step(0, 250, 2, 1'b1);
    check_bit(flags[0], 1'b1);
    step(0, 1, 2, 1'b0);
    step(0, 4, 3, 1'b0);
    step(0, 1, 3, 1'b0);
    check_word({23'h0, data_out}, 32'hff);
    $display("Standard timing test done");
    do_reset(1'b1, 1'b1);
    rd_check(fifo_pkg::STATUS_ADDR, 32'h57);
    rd_check(fifo_pkg::EMPTY_OFF_ADDR, 32'hff);
    serial_load(16'h0302);
    rd_check(fifo_pkg::EMPTY_OFF_ADDR, 32'h2);
    rd_check(fifo_pkg::FULL_OFF_ADDR, 32'h3);
    step(1, 0, 5, 1'b0);
    check_word({23'h0, data_out}, 32'((pushed - 1) % 512));
    step(2, 0, 2, 1'b0);
    step(1, 0, 2, 1'b1);
    step(125, 0, 0, 1'b1);
    step(1, 0, 0, 1'b0);
    step(123, 0, 1, 1'b1);
    step(1, 0, 1, 1'b0);
    step(2, 0, 6, 1'b0);
    step(1, 0, 6, 1'b1);
    rd_check(fifo_pkg::LEVEL_ADDR, 32'h101);
    step(0, 1, 6, 1'b0);
    check_word({23'h0, data_out}, 32'((pushed - 256) % 512));
    step(0, 252, 2, 1'b1);
    step(0, 1, 2, 1'b0);
    step(0, 3, 5, 1'b1);
    $display("Fall-through timing test done");
    final_report();
  end
endmodule : dual_clock_fifo_status_flags_bench
